// ---- dcp_pkg.sv ----
// Shared constants for the DMA channel priority arbiter and its channels.
// What this block does
// - Control bit 0 selects round-robin or channel-1 first.
// - Software changes priority only with channels disabled.
// - Software restarts arbitration after changing priority.
// - Control writes count only while unlock is open.
// - Status bits 2-0 show the active channel.
// - Channel-1 preemption copies active field into shadow.
// - Channel-1 completion copies shadow back to active.
// - Shadow zero or equal active means nothing pending.
// - Shadow codes: 000 none, 001-110 channels, 111 unused.
// - Software ignores shadow field in round-robin mode.
// - Restart resets sequencer to first enabled channel.
`default_nettype none

package dcp_pkg;
    // ==========================================================
    // Register map
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STAT_OFFSET = 4'h4;
    localparam int CTRL_SEL_BIT = 0;
    localparam int STAT_ACTIVE_LSB = 0;
    localparam int STAT_SHADOW_LSB = 4;
    localparam logic CTRL_SEL_RESET = 1'b0;
    // ==========================================================
    // Channel coding
    localparam int NUM_CH = 6;
    localparam int CODE_W = 3;
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_CH1 = 3'h1;
    localparam int BURST_WORDS = 4;
endpackage : dcp_pkg

`default_nettype wire

// ---- dcp_link_if.sv ----
// Link between the priority arbiter and the six transfer channels.
`default_nettype none

interface dcp_link_if;
    logic [5:0] req;
    logic [5:0] en;
    logic [5:0] done;
    logic [5:0] grant;

    modport arbiter (
        input req,
        input en,
        input done,
        output grant
    );

    modport channels (
        output req,
        output en,
        output done,
        input grant
    );
endinterface : dcp_link_if

`default_nettype wire

// ---- dcp_arbiter.sv ----
// Channel priority arbiter with its control and status registers.
//
// Our own choices: the plain strobed port and the placing of the registers.
`default_nettype none

module dcp_arbiter (
    input wire logic clk_sys,
    input wire logic nrst,
    dcp_link_if.arbiter link,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    input wire logic protected_write_unlock,
    input wire logic arbitration_restart
);
    // ==========================================================
    // Helpers
    function automatic logic [2:0] rr_pick(
        input logic [2:0] last,
        input logic [5:0] mask
    );
        int c;
        rr_pick = dcp_pkg::CODE_NONE;
        for (int k = dcp_pkg::NUM_CH; k >= 1; k--) begin
            c = (int'(last) + k - 1) % dcp_pkg::NUM_CH;
            if (mask[c]) begin
                rr_pick = 3'(c + 1);
            end
        end
    endfunction : rr_pick

    function automatic logic code_done(
        input logic [2:0] code,
        input logic [5:0] done
    );
        code_done = 1'b0;
        for (int i = 0; i < dcp_pkg::NUM_CH; i++) begin
            if (code == 3'(i + 1) && done[i]) begin
                code_done = 1'b1;
            end
        end
    endfunction : code_done

    // ==========================================================
    // State
    logic first_channel_preempt_select_reg;
    logic first_channel_preempt_select_next;
    logic [2:0] current_channel_indicator_reg;
    logic [2:0] current_channel_indicator_next;
    logic [2:0] preempted_channel_record_reg;
    logic [2:0] preempted_channel_record_next;
    logic [2:0] last_reg;
    logic [2:0] last_next;
    logic restart_pend_reg;
    logic restart_pend_next;
    logic [5:0] grant_reg;
    logic [5:0] grant_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [5:0] ready;
    logic [2:0] last_eff;
    logic [2:0] pick;

    assign ready = link.req & link.en;
    assign link.grant = grant_reg;
    assign rdata = rdata_reg;

    always_comb begin
        first_channel_preempt_select_next = first_channel_preempt_select_reg;
        current_channel_indicator_next = current_channel_indicator_reg;
        preempted_channel_record_next = preempted_channel_record_reg;
        last_next = last_reg;
        restart_pend_next = restart_pend_reg | arbitration_restart;
        rdata_next = '0;
        last_eff = last_reg;
        pick = dcp_pkg::CODE_NONE;

        // Register port.
        if (wr_stb && protected_write_unlock
            && addr == dcp_pkg::CTRL_OFFSET) begin
            first_channel_preempt_select_next =
                wdata[dcp_pkg::CTRL_SEL_BIT];
        end
        if (rd_stb) begin
            case (addr)
                dcp_pkg::CTRL_OFFSET: begin
                    rdata_next[dcp_pkg::CTRL_SEL_BIT] =
                        first_channel_preempt_select_reg;
                end
                dcp_pkg::STAT_OFFSET: begin
                    rdata_next[dcp_pkg::STAT_ACTIVE_LSB +: 3] =
                        current_channel_indicator_reg;
                    rdata_next[dcp_pkg::STAT_SHADOW_LSB +: 3] =
                        preempted_channel_record_reg;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end

        // A channel that finished its last word just as channel 1 took
        // over must not be resumed, or it would hold the grant forever.
        if (preempted_channel_record_reg != current_channel_indicator_reg
            && code_done(preempted_channel_record_reg, link.done)) begin
            preempted_channel_record_next = dcp_pkg::CODE_NONE;
        end

        if (current_channel_indicator_reg != dcp_pkg::CODE_NONE) begin
            if (code_done(current_channel_indicator_reg, link.done)) begin
                if (current_channel_indicator_reg == dcp_pkg::CODE_CH1
                    && first_channel_preempt_select_reg) begin
                    current_channel_indicator_next =
                        preempted_channel_record_next;
                end else begin
                    current_channel_indicator_next = dcp_pkg::CODE_NONE;
                end
            end else if (first_channel_preempt_select_reg && ready[0]
                && current_channel_indicator_reg != dcp_pkg::CODE_CH1) begin
                preempted_channel_record_next =
                    current_channel_indicator_reg;
                current_channel_indicator_next = dcp_pkg::CODE_CH1;
            end
        end else begin
            // Restart waits for an idle sequencer so no burst is cut short.
            if (restart_pend_reg) begin
                last_eff = first_channel_preempt_select_reg ?
                    dcp_pkg::CODE_CH1 : dcp_pkg::CODE_NONE;
                restart_pend_next = arbitration_restart;
            end
            if (first_channel_preempt_select_reg && ready[0]) begin
                pick = dcp_pkg::CODE_CH1;
                preempted_channel_record_next = dcp_pkg::CODE_NONE;
            end else begin
                pick = rr_pick(last_eff, ready);
            end
            current_channel_indicator_next = pick;
            if (pick != dcp_pkg::CODE_NONE) begin
                last_next = pick;
            end else begin
                last_next = last_eff;
            end
        end

        grant_next = '0;
        for (int i = 0; i < dcp_pkg::NUM_CH; i++) begin
            grant_next[i] = (current_channel_indicator_next == 3'(i + 1));
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            first_channel_preempt_select_reg <= dcp_pkg::CTRL_SEL_RESET;
            current_channel_indicator_reg <= dcp_pkg::CODE_NONE;
            preempted_channel_record_reg <= dcp_pkg::CODE_NONE;
            last_reg <= dcp_pkg::CODE_NONE;
            restart_pend_reg <= 1'b0;
            grant_reg <= '0;
            rdata_reg <= '0;
        end else begin
            first_channel_preempt_select_reg <=
                first_channel_preempt_select_next;
            current_channel_indicator_reg <= current_channel_indicator_next;
            preempted_channel_record_reg <= preempted_channel_record_next;
            last_reg <= last_next;
            restart_pend_reg <= restart_pend_next;
            grant_reg <= grant_next;
            rdata_reg <= rdata_next;
        end
    end
endmodule : dcp_arbiter

`default_nettype wire

// ---- dcp_channels.sv ----
// Six transfer channels that request bursts from the priority arbiter.
`default_nettype none

module dcp_channels #(
    parameter int BURST = dcp_pkg::BURST_WORDS
) (
    input wire logic clk_sys,
    input wire logic nrst,
    dcp_link_if.channels link,
    input wire logic [5:0] start,
    input wire logic [5:0] enable,
    output logic [5:0] busy,
    output logic [5:0] word_xfer
);
    // ==========================================================
    // Per-channel burst engines
    logic [5:0] pend_reg;
    logic [5:0] en_reg;
    logic [5:0] done_reg;
    logic [5:0] xfer_reg;

    assign link.req = pend_reg;
    assign link.en = en_reg;
    assign link.done = done_reg;
    assign busy = pend_reg;
    assign word_xfer = xfer_reg;

    for (genvar i = 0; i < dcp_pkg::NUM_CH; i++) begin : g_ch
        logic [7:0] cnt_reg;
        logic [7:0] cnt_next;
        logic pend_next;
        logic done_next;
        logic xfer_next;

        // The word count survives a preemption, so a resumed burst
        // carries on where it stopped instead of starting over.
        always_comb begin
            pend_next = pend_reg[i] | start[i];
            cnt_next = cnt_reg;
            done_next = 1'b0;
            xfer_next = 1'b0;
            if (link.grant[i] && !done_reg[i] && pend_reg[i]) begin
                xfer_next = 1'b1;
                if (cnt_reg == 8'(BURST - 1)) begin
                    cnt_next = '0;
                    done_next = 1'b1;
                    pend_next = start[i];
                end else begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
        end

        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                cnt_reg <= '0;
                pend_reg[i] <= 1'b0;
                done_reg[i] <= 1'b0;
                xfer_reg[i] <= 1'b0;
                en_reg[i] <= 1'b0;
            end else begin
                cnt_reg <= cnt_next;
                pend_reg[i] <= pend_next;
                done_reg[i] <= done_next;
                xfer_reg[i] <= xfer_next;
                en_reg[i] <= enable[i];
            end
        end
    end
endmodule : dcp_channels

`default_nettype wire

// ---- dcp_link_asserts.sv ----
// Concurrent checks on the link between arbiter and channels.
`default_nettype none

module dcp_link_asserts (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [5:0] req,
    input wire logic [5:0] en,
    input wire logic [5:0] done,
    input wire logic [5:0] grant
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_idle_req;
        grant == 6'h00 ##0 |(req & en);
    endsequence
    sequence s_finish;
        |(done & grant);
    endsequence
    a_grant_one_hot: assert property ($onehot0(grant))
        else $error("grant not one-hot");
    a_done_one_hot: assert property ($onehot0(done))
        else $error("two bursts finished together");
    a_idle_grants_next: assert property (s_idle_req |=> grant != 6'h00)
        else $error("pending request not granted");
    a_idle_stays_idle: assert property (
        grant == 6'h00 && (req & en) == 6'h00 |=> grant == 6'h00)
        else $error("grant without request");
    a_done_drops_grant: assert property (
        s_finish |=> (grant & $past(done)) == 6'h00)
        else $error("grant held after burst end");
    a_grant_holds: assert property (
        grant != 6'h00 && done == 6'h00 && !(req[0] && en[0])
        |=> $stable(grant))
        else $error("grant moved mid burst");
    a_new_grant_asked: assert property (
        grant != $past(grant) && grant != 6'h00
        |-> (grant & $past(req & en)) != 6'h00)
        else $error("grant to channel not requesting");
    a_ch1_wins_idle: assert property (
        s_idle_req ##0 (req[0] && en[0] && (req & en) == 6'h01)
        |=> grant == 6'h01)
        else $error("lone channel 1 request not served");
endmodule : dcp_link_asserts

`default_nettype wire

// ---- dma_channel_priority_arbiter_tb_top.sv ----
// Self-checking bench joining the arbiter to the six channels.
`default_nettype none

module dma_channel_priority_arbiter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [15:0] rdata;
    logic unlock = 1'b0;
    logic restart = 1'b0;
    logic [5:0] start = 6'h00;
    logic [5:0] enable = 6'h00;
    localparam int TB_BURST = 8;
    logic [5:0] busy;
    logic [5:0] word_xfer;
    int failures = 0;
    int checks_done = 0;
    int words_seen = 0;
    dcp_link_if link();
    dcp_arbiter dcp_arbiter_inst (.clk_sys(clk_sys), .nrst(nrst),
        .link(link), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .protected_write_unlock(unlock),
        .arbitration_restart(restart));
    dcp_channels #(.BURST(TB_BURST)) dcp_channels_inst (.clk_sys(clk_sys),
        .nrst(nrst), .link(link), .start(start), .enable(enable),
        .busy(busy), .word_xfer(word_xfer));
    dcp_link_asserts dcp_link_asserts_inst (.clk_sys(clk_sys), .nrst(nrst),
        .req(link.req), .en(link.en), .done(link.done),
        .grant(link.grant));
    // Every word moved is counted, so a resumed burst that restarted its
    // count or skipped words shows up in the total.
    always @(posedge clk_sys) begin
        words_seen <= words_seen + $countones(word_xfer);
    end
    // ==========================================================
    // Access tasks
    task summarize;
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask : rd
    task kick(input logic [5:0] m, input logic rs);
        @(posedge clk_sys);
        start <= m;
        restart <= rs;
        @(posedge clk_sys);
        start <= 6'h00;
        restart <= 1'b0;
    endtask : kick
    // Waiting on the grant bounds the time a lost request can hang.
    task wait_grant(input logic [5:0] m);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (link.grant !== m && n < 100);
        chk("grant", {10'h000, m}, {10'h000, link.grant});
    endtask : wait_grant
    // ==========================================================
    // Tests
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (4000) @(posedge clk_sys);
        failures++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(dcp_pkg::CTRL_OFFSET, 16'h0000);
        rd(dcp_pkg::STAT_OFFSET, 16'h0000);
        wr(dcp_pkg::CTRL_OFFSET, 16'hffff);
        rd(dcp_pkg::CTRL_OFFSET, 16'h0000);
        wr(dcp_pkg::STAT_OFFSET, 16'hffff);
        rd(dcp_pkg::STAT_OFFSET, 16'h0000);
        rd(4'hc, 16'h0000);
        @(posedge clk_sys);
        enable <= 6'h3f;
        kick(6'h02, 1'b0);
        wait_grant(6'h02);
        rd(dcp_pkg::STAT_OFFSET, 16'h0002);
        wait_grant(6'h00);
        kick(6'h05, 1'b0);
        wait_grant(6'h04);
        wait_grant(6'h01);
        wait_grant(6'h00);
        kick(6'h00, 1'b1);
        kick(6'h05, 1'b0);
        wait_grant(6'h01);
        wait_grant(6'h04);
        wait_grant(6'h00);
        @(posedge clk_sys);
        enable <= 6'h00;
        unlock <= 1'b1;
        wr(dcp_pkg::CTRL_OFFSET, 16'hffff);
        unlock <= 1'b0;
        rd(dcp_pkg::CTRL_OFFSET, 16'h0001);
        kick(6'h00, 1'b1);
        enable <= 6'h3f;
        kick(6'h08, 1'b0);
        wait_grant(6'h08);
        kick(6'h01, 1'b0);
        wait_grant(6'h01);
        rd(dcp_pkg::STAT_OFFSET, 16'h0041);
        wait_grant(6'h08);
        rd(dcp_pkg::STAT_OFFSET, 16'h0044);
        wait_grant(6'h00);
        rd(dcp_pkg::STAT_OFFSET, 16'h0040);
        // Channel 4 was served last, so only a restart puts channel 2
        // ahead of channel 6 here.
        kick(6'h00, 1'b1);
        kick(6'h22, 1'b0);
        wait_grant(6'h02);
        wait_grant(6'h20);
        wait_grant(6'h00);
        kick(6'h01, 1'b0);
        wait_grant(6'h01);
        rd(dcp_pkg::STAT_OFFSET, 16'h0001);
        wait_grant(6'h00);
        chk("busy", 16'h0000, {10'h000, busy});
        chk("words", 16'(10 * TB_BURST), 16'(words_seen));
        summarize();
    end
endmodule : dma_channel_priority_arbiter_tb_top

`default_nettype wire
